/* File: inc/sxp_defines.svh */
// Constants for the serial expander front end: bus codes, identity word
// defaults, controller register map and link timing.
// Assumes a 200 MHz system clock on both ends of the link.
//
// Notes on behaviour
// - Pin combination selects fixed seven-bit slave address.
// - Acknowledge general call only for byte 00h.
// - General call with read bit gets no acknowledge.
// - After general call, acknowledge only data 06h.
// - Further bytes after reset byte are refused.
// - Stop after accepted 06h resets all state; the select-pin detectors, line synchronizers and own_q keep theirs.
// - Repeated start after 06h cancels the reset.
// - Master treats any refusal as aborted reset.
// - Fixed 24-bit identity: maker, part, revision.
// - Identity access starts with write byte F8h.
// - Next byte names target; low bit ignored.
// - Repeated start, then F9h, then identity bytes.
// - Stop or other access cancels identity read.
// - Identity sent maker first, revision last.
// - Master refusal ends identity read, slave idles.
// - Continued acknowledges wrap to first identity byte.
// - First byte low bit: one read, zero write.
// - Each select pin: ground, supply, clock, data.
`ifndef SXP_DEFINES_SVH
`define SXP_DEFINES_SVH

`define SXP_GC_BYTE      8'h00
`define SXP_SWRST_BYTE   8'h06
`define SXP_IDW_BYTE     8'hF8
`define SXP_IDR_BYTE     8'hF9

// Identity defaults are arbitrary values.
`define SXP_ID_MFR       12'h5A3
`define SXP_ID_PART      9'h0C6
`define SXP_ID_REV       3'h1

`define SXP_REG_CMD      2'h0
`define SXP_REG_TXD      2'h1
`define SXP_REG_STAT     2'h2
`define SXP_REG_RXD      2'h3

`define SXP_CMD_START    0
`define SXP_CMD_BYTE     1
`define SXP_CMD_READ     2
`define SXP_CMD_NACK     3
`define SXP_CMD_STOP     4

`define SXP_CLK_NS       5
`define SXP_QTR_NS       100
`define SXP_QTR_CYC      (`SXP_QTR_NS / `SXP_CLK_NS)

`endif

/* File: inc/sxp_pkg.sv */
// Types shared by both ends of the serial expander link.
// Assumes nothing beyond the defines header.
package sxp_pkg;
  typedef enum logic [1:0] {
    SXP_PIN_GND, SXP_PIN_VDD, SXP_PIN_SCL, SXP_PIN_SDA
  } sxp_pin_t;
  typedef enum logic [2:0] {
    SXP_D_IDLE, SXP_D_RX, SXP_D_ACK, SXP_D_TX, SXP_D_MACK
  } sxp_dst_t;
  typedef enum logic [2:0] {
    SXP_C_ADDR, SXP_C_GC, SXP_C_IDW, SXP_C_DONE,
    SXP_C_OWNW, SXP_C_OWNR, SXP_C_IDR
  } sxp_ctx_t;
  typedef enum logic [1:0] {
    SXP_H_IDLE, SXP_H_START, SXP_H_BIT, SXP_H_STOP
  } sxp_hst_t;
endpackage

/* File: inc/sxp_link_if.sv */
// Two-wire link between controller and expander front end.
// Both lines are open drain; an enable pulls the line low.
`timescale 1ns/1ps
`default_nettype none
interface sxp_link_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  wire  scl;
  wire  sda;
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host (output host_scl_oe, output host_sda_oe, input sda);
  modport dev  (output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

/* File: rtl/sxp_dev.sv */
// Expander front end: address decode from select pins, general call
// software reset and identity read.
// Assumes the link lines are asynchronous to sys_clk and slow against it.
//
// Decided for this implementation: the plain strobed port and the address map.
`include "sxp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sxp_dev #(
  parameter logic [11:0] ID_MFR  = `SXP_ID_MFR,
  parameter logic [8:0]  ID_PART = `SXP_ID_PART,
  parameter logic [2:0]  ID_REV  = `SXP_ID_REV
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Link
  sxp_link_if.dev         link,
  // Address select pins
  input  wire logic       addr_select_pin_high,
  input  wire logic       addr_select_pin_mid,
  input  wire logic       addr_select_pin_low,
  // Port data
  input  wire logic [7:0] port_rd_data,
  output logic            port_wr_stb,
  output logic      [7:0] port_wr_data,
  // Status
  output logic            soft_rst,
  output logic      [6:0] own_addr
);
  import sxp_pkg::*;

  logic              scl_m_q, scl_s_q, scl_p_q;
  logic              sda_m_q, sda_s_q, sda_p_q;
  logic        [2:0] pin_raw;
  logic        [1:0] pin_code [3];
  logic        [6:0] own_q;
  sxp_dst_t          state_q;
  sxp_ctx_t          ctx_q;
  logic        [3:0] cnt_q;
  logic        [7:0] sh_q;
  logic              ack_q, mack_q, oe_q;
  logic              armed_q, pend_q, srst_q;
  logic        [1:0] idx_q;
  logic              wr_stb_q;
  logic        [7:0] wr_data_q;

  assign pin_raw = {addr_select_pin_high, addr_select_pin_mid,
                    addr_select_pin_low};

  // Pins go through the same two stages as the bus lines, so a pin tied
  // to a bus line stays cycle-aligned with that line's sampled copy.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= link.scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_ev  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // A pin that has toggled and never differed from a bus line is tied to
  // it; otherwise its present level is taken as a static strap.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      logic m_q, s_q, hi_q, lo_q, nscl_q, nsda_q;
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          // Stages start at the idle level of the bus lines, so a pin tied
          // to a line does not differ from it at the first edge.
          m_q    <= 1'b1;
          s_q    <= 1'b1;
          hi_q   <= 1'b0;
          lo_q   <= 1'b0;
          nscl_q <= 1'b0;
          nsda_q <= 1'b0;
        end else begin
          m_q    <= pin_raw[gi];
          s_q    <= m_q;
          hi_q   <= hi_q | s_q;
          lo_q   <= lo_q | ~s_q;
          nscl_q <= nscl_q | (s_q ^ scl_s_q);
          nsda_q <= nsda_q | (s_q ^ sda_s_q);
        end
      end
      wire toggled = hi_q & lo_q;
      assign pin_code[gi] = (toggled & ~nscl_q) ? SXP_PIN_SCL :
                            (toggled & ~nsda_q) ? SXP_PIN_SDA :
                            s_q                 ? SXP_PIN_VDD :
                                                  SXP_PIN_GND;
    end
  endgenerate

  // Upper bit of each code marks a bus-tied pin; lower bit is its level, or for a tied pin is set for SDA.
  wire d2 = pin_code[2][1];
  wire d1 = pin_code[1][1];
  wire d0 = pin_code[0][1];
  wire [6:0] addr_map = {d2, ~d1, d1 | (d2 & d0 & ~d1),
                         d0 & ~(d2 & ~d1),
                         pin_code[2][0], pin_code[1][0], pin_code[0][0]};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      own_q <= 7'h00;
    end else begin
      own_q <= addr_map;
    end
  end

  // Byte decisions, taken on the eighth rising clock of a received byte.
  wire [7:0] rx_byte = {sh_q[6:0], sda_s_q};
  wire is_gc    = rx_byte == `SXP_GC_BYTE;
  wire is_idw   = rx_byte == `SXP_IDW_BYTE;
  wire is_idr   = rx_byte == `SXP_IDR_BYTE;
  wire is_own   = rx_byte[7:1] == own_q;
  wire is_swrst = rx_byte == `SXP_SWRST_BYTE;
  wire tgt_ok   = rx_byte[7:1] == own_q;
  wire addr_ack = is_gc | is_idw | (is_idr & armed_q) | is_own;
  sxp_ctx_t addr_ctx;
  assign addr_ctx = is_gc  ? SXP_C_GC  :
                    is_idw ? SXP_C_IDW :
                    is_idr ? SXP_C_IDR :
                    rx_byte[0] ? SXP_C_OWNR : SXP_C_OWNW;
  wire dec_ack = (ctx_q == SXP_C_ADDR) ? addr_ack :
                 (ctx_q == SXP_C_GC)   ? is_swrst :
                 (ctx_q == SXP_C_IDW)  ? tgt_ok   :
                 (ctx_q == SXP_C_OWNW);
  sxp_ctx_t dec_ctx;
  assign dec_ctx = (ctx_q == SXP_C_ADDR) ? addr_ctx :
                   (ctx_q == SXP_C_OWNW) ? SXP_C_OWNW :
                                           SXP_C_DONE;
  wire last_rx = (state_q == SXP_D_RX) & scl_rise & (cnt_q == 4'h7);

  wire [23:0] id_word = {ID_MFR, ID_PART, ID_REV};
  wire [7:0]  id_byte = (idx_q == 2'h0) ? id_word[23:16] :
                        (idx_q == 2'h1) ? id_word[15:8]  :
                                          id_word[7:0];
  wire ctx_tx = (ctx_q == SXP_C_OWNR) | (ctx_q == SXP_C_IDR);
  wire [7:0] tx_byte = (ctx_q == SXP_C_IDR) ? id_byte : port_rd_data;
  wire tx_load = scl_fall &
                 (((state_q == SXP_D_ACK) & ack_q & ctx_tx) |
                  ((state_q == SXP_D_MACK) & mack_q));

  always_ff @(posedge sys_clk) begin
    if (!rst_n || srst_q) begin
      state_q   <= SXP_D_IDLE;
      ctx_q     <= SXP_C_ADDR;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      ack_q     <= 1'b0;
      mack_q    <= 1'b0;
      oe_q      <= 1'b0;
      armed_q   <= 1'b0;
      pend_q    <= 1'b0;
      srst_q    <= 1'b0;
      idx_q     <= 2'h0;
      wr_stb_q  <= 1'b0;
      wr_data_q <= 8'hFF;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_ev) begin
        state_q <= SXP_D_RX;
        ctx_q   <= SXP_C_ADDR;
        cnt_q   <= 4'h0;
        oe_q    <= 1'b0;
        idx_q   <= 2'h0;
        pend_q  <= 1'b0;
      end else if (stop_ev) begin
        state_q <= SXP_D_IDLE;
        oe_q    <= 1'b0;
        armed_q <= 1'b0;
        srst_q  <= pend_q;
        pend_q  <= 1'b0;
      end else if (tx_load) begin
        state_q <= SXP_D_TX;
        cnt_q   <= 4'h0;
        sh_q    <= tx_byte;
        oe_q    <= ~tx_byte[7];
        idx_q   <= (idx_q == 2'h2) ? 2'h0 : 2'(idx_q + 2'h1);
      end else begin
        unique case (state_q)
          SXP_D_IDLE: begin
            oe_q <= 1'b0;
          end
          SXP_D_RX: begin
            if (scl_rise) begin
              sh_q  <= rx_byte;
              cnt_q <= 4'(cnt_q + 4'h1);
            end else if (scl_fall && cnt_q == 4'h8) begin
              state_q <= SXP_D_ACK;
              oe_q    <= ack_q;
            end
            if (last_rx) begin
              ack_q <= dec_ack;
              ctx_q <= dec_ctx;
              if (ctx_q == SXP_C_GC) begin
                pend_q <= is_swrst;
              end else if (ctx_q != SXP_C_ADDR) begin
                pend_q <= 1'b0;
              end
              if (ctx_q == SXP_C_IDW) begin
                armed_q <= tgt_ok;
              end else if (ctx_q == SXP_C_ADDR && !is_idr) begin
                armed_q <= 1'b0;
              end
              if (ctx_q == SXP_C_OWNW) begin
                wr_stb_q  <= 1'b1;
                wr_data_q <= rx_byte;
              end
            end
          end
          SXP_D_ACK: begin
            if (scl_fall) begin
              cnt_q   <= 4'h0;
              oe_q    <= 1'b0;
              state_q <= ack_q ? SXP_D_RX : SXP_D_IDLE;
            end
          end
          SXP_D_TX: begin
            if (scl_rise) begin
              cnt_q <= 4'(cnt_q + 4'h1);
            end else if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                state_q <= SXP_D_MACK;
                oe_q    <= 1'b0;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                oe_q <= ~sh_q[6];
              end
            end
          end
          SXP_D_MACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s_q;
            end else if (scl_fall) begin
              state_q <= SXP_D_IDLE;
              idx_q   <= 2'h0;
            end
          end
        endcase
      end
    end
  end

  assign link.dev_sda_oe = oe_q;
  assign port_wr_stb     = wr_stb_q;
  assign port_wr_data    = wr_data_q;
  assign soft_rst        = srst_q;
  assign own_addr        = own_q;
endmodule // sxp_dev
`default_nettype wire

/* File: rtl/sxp_host.sv */
// Link controller: runs start, byte and stop steps ordered through a
// small register port and makes the link clock by division.
// Assumes the far end answers within one quarter of a link bit.
`include "sxp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sxp_host (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Link
  sxp_link_if.host        link,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata
);
  import sxp_pkg::*;

  localparam logic [7:0] QTR_LAST = 8'(`SXP_QTR_CYC - 1);

  logic       sda_m_q, sda_s_q;
  sxp_hst_t   state_q;
  logic [4:0] cmd_q;
  logic [7:0] txd_q, sh_q, rxd_q, rdata_q, qcnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic       busy_q, nack_q, scl_oe_q, sda_oe_q;

  wire tick     = qcnt_q == QTR_LAST;
  wire ph_end   = tick & (ph_q == 2'h3);
  wire go       = reg_wr & (reg_addr == `SXP_REG_CMD) & ~busy_q;
  wire do_read  = cmd_q[`SXP_CMD_READ];
  wire do_stop  = cmd_q[`SXP_CMD_STOP];
  wire is_ack   = bit_q == 4'h8;
  wire bit_val  = is_ack ? (do_read & ~cmd_q[`SXP_CMD_NACK]) :
                           (~do_read & ~sh_q[7]);
  wire [7:0] rd_mux = (reg_addr == `SXP_REG_CMD)  ? {3'h0, cmd_q} :
                      (reg_addr == `SXP_REG_TXD)  ? txd_q :
                      (reg_addr == `SXP_REG_STAT) ? {6'h00, nack_q, busy_q} :
                                                    rxd_q;
  sxp_hst_t first_st;
  assign first_st = reg_wdata[`SXP_CMD_START] ? SXP_H_START :
                    reg_wdata[`SXP_CMD_BYTE]  ? SXP_H_BIT   :
                    reg_wdata[`SXP_CMD_STOP]  ? SXP_H_STOP  : SXP_H_IDLE;
  sxp_hst_t after_st;
  assign after_st = (state_q == SXP_H_START && cmd_q[`SXP_CMD_BYTE]) ?
                    SXP_H_BIT :
                    (state_q != SXP_H_STOP && do_stop) ? SXP_H_STOP :
                    SXP_H_IDLE;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q  <= SXP_H_IDLE;
      cmd_q    <= 5'h00;
      txd_q    <= 8'h00;
      sh_q     <= 8'h00;
      rxd_q    <= 8'h00;
      rdata_q  <= 8'h00;
      qcnt_q   <= 8'h00;
      ph_q     <= 2'h0;
      bit_q    <= 4'h0;
      busy_q   <= 1'b0;
      nack_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
      if (reg_wr && reg_addr == `SXP_REG_TXD && !busy_q) begin
        txd_q <= reg_wdata;
      end
      qcnt_q <= (state_q == SXP_H_IDLE || tick) ? 8'h00 :
                8'(qcnt_q + 8'h01);
      if (go) begin
        cmd_q   <= reg_wdata[4:0];
        state_q <= first_st;
        busy_q  <= first_st != SXP_H_IDLE;
        sh_q    <= txd_q;
        bit_q   <= 4'h0;
        ph_q    <= 2'h0;
        if (reg_wdata[`SXP_CMD_BYTE]) begin
          nack_q <= 1'b0;
        end
      end else if (tick) begin
        ph_q <= 2'(ph_q + 2'h1);
        unique case (state_q)
          SXP_H_IDLE: begin
            ph_q <= 2'h0;
          end
          SXP_H_START: begin
            // Release data, raise clock, pull data low, pull clock low.
            unique case (ph_q)
              2'h0: sda_oe_q <= 1'b0;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1;
              2'h3: scl_oe_q <= 1'b1;
            endcase
          end
          SXP_H_BIT: begin
            unique case (ph_q)
              2'h0: sda_oe_q <= bit_val;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: begin
                if (is_ack && !do_read) begin
                  nack_q <= sda_s_q;
                end else if (!is_ack && do_read) begin
                  rxd_q <= {rxd_q[6:0], sda_s_q};
                end
              end
              2'h3: begin
                scl_oe_q <= 1'b1;
                sh_q     <= {sh_q[6:0], 1'b0};
                bit_q    <= 4'(bit_q + 4'h1);
              end
            endcase
          end
          SXP_H_STOP: begin
            unique case (ph_q)
              2'h0: sda_oe_q <= 1'b1;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b0;
              2'h3: ;
            endcase
          end
        endcase
        if (ph_end && (state_q != SXP_H_BIT || is_ack)) begin
          state_q <= after_st;
          busy_q  <= after_st != SXP_H_IDLE;
          bit_q   <= 4'h0;
        end
      end
    end
  end

  assign link.host_scl_oe = scl_oe_q;
  assign link.host_sda_oe = sda_oe_q;
  assign reg_rdata        = rdata_q;
endmodule // sxp_host
`default_nettype wire

/* File: dv/sxp_link_monitor.sv */
// Checker for the link: framing, acknowledge slots and slave drive timing.
// Assumes it sees the interface signals in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module sxp_link_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q, sda_q, act_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] sh_q, first_q;
  wire start_w = scl & scl_q & sda_q & ~sda;
  wire stop_w  = scl & scl_q & ~sda_q & sda;
  wire rise_w  = scl & ~scl_q;
  wire ack_w   = rise_w & (bit_q == 4'h8);
  wire gc_w    = (first_q == 8'h00) & (byte_q != 3'h0);
  // The byte count saturates so that long reads never look like byte 1.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      {scl_q, sda_q, act_q} <= 3'h6;
      {bit_q, byte_q, sh_q, first_q} <= {4'h0, 3'h0, 8'h00, 8'hFF};
    end else begin
      {scl_q, sda_q} <= {scl, sda};
      act_q <= start_w | (act_q & ~stop_w);
      if (start_w) begin
        {bit_q, byte_q} <= {4'h0, 3'h0};
      end else if (rise_w) begin
        bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
        if (!ack_w) sh_q <= {sh_q[6:0], sda};
        else if (byte_q != 3'h7) byte_q <= byte_q + 3'h1;
        if (ack_w && byte_q == 3'h0) first_q <= sh_q;
      end
    end
  end
  sequence s_gc_data;
    ack_w && gc_w && byte_q == 3'h1;
  endsequence
  sequence s_gc_more;
    ack_w && gc_w && byte_q > 3'h1;
  endsequence
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_drive_hold: assert property (
    scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("slave moved data");
  a_drive_late: assert property (
    $changed(dev_sda_oe) |-> !scl && !$past(scl, 2) && $past(scl, 8))
    else $error("slave drive not just after clock fall");
  a_gc_ack: assert property (
    ack_w && byte_q == 3'h0 && sh_q == 8'h00 |-> !sda)
    else $error("call address not acknowledged");
  a_gc_read_nack: assert property (
    ack_w && byte_q == 3'h0 && sh_q == 8'h01 |-> sda)
    else $error("call read acknowledged");
  a_id_addr_ack: assert property (
    ack_w && byte_q == 3'h0 && sh_q == 8'hF8 |-> !sda)
    else $error("identity address not acknowledged");
  a_gc_data_ack: assert property (
    s_gc_data |-> sda == (sh_q != 8'h06)) else $error("reset byte answer");
  a_gc_more_nack: assert property (
    s_gc_more |-> sda) else $error("extra call byte acknowledged");
  a_rd_release: assert property (
    ack_w && first_q[0] && byte_q != 3'h0 |-> !dev_sda_oe)
    else $error("slave drives master acknowledge slot");
  a_idle_quiet: assert property (
    !act_q |-> !dev_sda_oe) else $error("slave drives idle bus");
endmodule // sxp_link_monitor
`default_nettype wire

/* File: dv/sxp_tb.sv */
// Bench: controller and expander joined by the link, driven through the
// controller register port. Assumes the defines header and the package.
`include "sxp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sxp_tb;
  import sxp_pkg::*;
  localparam logic [7:0]  C_S  = 8'h01 << `SXP_CMD_START;
  localparam logic [7:0]  C_B  = 8'h01 << `SXP_CMD_BYTE;
  localparam logic [7:0]  C_R  = 8'h01 << `SXP_CMD_READ;
  localparam logic [7:0]  C_N  = 8'h01 << `SXP_CMD_NACK;
  localparam logic [7:0]  C_P  = 8'h01 << `SXP_CMD_STOP;
  localparam logic [23:0] ID_W = {`SXP_ID_MFR, `SXP_ID_PART, `SXP_ID_REV};
  logic       sys_clk, rst_n, reg_wr, reg_rd, port_wr_stb, soft_rst;
  logic       pin_hi, pin_mid, pin_lo;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, port_rd_data, port_wr_data, st, rx;
  logic [6:0] own_addr, own;
  sxp_pin_t   sel [3];
  int         err_total, samples_checked, n_wr, n_rst;

  function automatic logic pick(sxp_pin_t p, logic c, logic d);
    case (p)
      SXP_PIN_GND: return 1'b0;
      SXP_PIN_VDD: return 1'b1;
      SXP_PIN_SCL: return c;
      default:     return d;
    endcase
  endfunction

  sxp_link_if u_sxp_link_if ();
  assign pin_hi  = pick(sel[0], u_sxp_link_if.scl, u_sxp_link_if.sda);
  assign pin_mid = pick(sel[1], u_sxp_link_if.scl, u_sxp_link_if.sda);
  assign pin_lo  = pick(sel[2], u_sxp_link_if.scl, u_sxp_link_if.sda);

  sxp_dev u_sxp_dev (.sys_clk(sys_clk), .rst_n(rst_n), .link(u_sxp_link_if),
    .addr_select_pin_high(pin_hi), .addr_select_pin_mid(pin_mid),
    .addr_select_pin_low(pin_lo), .port_rd_data(port_rd_data),
    .port_wr_stb(port_wr_stb), .port_wr_data(port_wr_data),
    .soft_rst(soft_rst), .own_addr(own_addr));
  sxp_host u_sxp_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(u_sxp_link_if),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  sxp_link_monitor u_sxp_link_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
    .host_scl_oe(u_sxp_link_if.host_scl_oe),
    .host_sda_oe(u_sxp_link_if.host_sda_oe),
    .dev_sda_oe(u_sxp_link_if.dev_sda_oe),
    .scl(u_sxp_link_if.scl), .sda(u_sxp_link_if.sda));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Strobes last one cycle, so they are counted rather than polled.
  always @(posedge sys_clk) begin
    if (port_wr_stb === 1'b1) n_wr <= n_wr + 1;
    if (soft_rst === 1'b1) n_rst <= n_rst + 1;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Busy is polled with a bound; the global limit catches a stuck link.
  task automatic op(input logic [7:0] cmd, input logic [7:0] txd);
    wr_reg(`SXP_REG_TXD, txd);
    wr_reg(`SXP_REG_CMD, cmd);
    st = 8'h01;
    for (int n = 0; n < 2000 && st[0] !== 1'b0; n++) rd_reg(`SXP_REG_STAT, st);
    chk({7'h00, st[0]}, 8'h00);
  endtask
  task automatic xb(input logic [7:0] cmd, input logic [7:0] txd, input nk);
    op(cmd, txd);
    chk({7'h00, st[1]}, {7'h00, nk});
  endtask
  task automatic xr(input logic [7:0] cmd, input logic [7:0] exp);
    op(cmd | C_B, 8'hFF);
    rd_reg(`SXP_REG_RXD, rx);
    chk(rx, exp);
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  task automatic t_addr_map();
    sxp_pin_t   tab [6][3] = '{
      '{SXP_PIN_SCL, SXP_PIN_SCL, SXP_PIN_GND},
      '{SXP_PIN_SDA, SXP_PIN_SDA, SXP_PIN_SDA},
      '{SXP_PIN_SCL, SXP_PIN_VDD, SXP_PIN_GND},
      '{SXP_PIN_SDA, SXP_PIN_SCL, SXP_PIN_VDD},
      '{SXP_PIN_SCL, SXP_PIN_GND, SXP_PIN_SCL},
      '{SXP_PIN_SDA, SXP_PIN_VDD, SXP_PIN_SDA}};
    logic [6:0] ea [6] = '{7'h50, 7'h5F, 7'h62, 7'h55, 7'h70, 7'h77};
    int         b;
    for (int i = 0; i < 6; i++) begin
      sel <= tab[i];
      do_reset();
      b = n_wr;
      xb(C_S | C_B, {ea[i], 1'b0}, 1'b0);
      xb(C_B | C_P, 8'hA0 + 8'(i), 1'b0);
      chk({1'b0, own_addr}, {1'b0, ea[i]});
      chk(port_wr_data, 8'hA0 + 8'(i));
      chk(8'(n_wr - b), 8'h01);
    end
    own = ea[5];
  endtask
  task automatic t_gc_refuse();
    int b;
    b = n_rst;
    xb(C_S | C_B | C_P, 8'h01, 1'b1);
    xb(C_S | C_B, 8'h00, 1'b0);
    xb(C_B | C_P, 8'h07, 1'b1);
    xb(C_S | C_B, 8'h00, 1'b0);
    xb(C_B, 8'h06, 1'b0);
    xb(C_B | C_P, 8'h06, 1'b1);
    xb(C_S | C_B, 8'h00, 1'b0);
    xb(C_B, 8'h06, 1'b0);
    xb(C_S | C_B | C_P, 8'hF8, 1'b0);
    chk(8'(n_rst - b), 8'h00);
  endtask
  task automatic t_swrst();
    int b;
    xb(C_S | C_B, {own, 1'b0}, 1'b0);
    xb(C_B | C_P, 8'h00, 1'b0);
    b = n_rst;
    xb(C_S | C_B, 8'h00, 1'b0);
    xb(C_B | C_P, 8'h06, 1'b0);
    chk(8'(n_rst - b), 8'h01);
    chk(port_wr_data, 8'hFF);
    xb(C_S | C_B | C_P, {own, 1'b0}, 1'b0);
  endtask
  task automatic t_ident();
    xb(C_S | C_B, 8'hF8, 1'b0);
    xb(C_B, {own, 1'b1}, 1'b0);
    xb(C_S | C_B, 8'hF9, 1'b0);
    xr(C_R, ID_W[23:16]);
    xr(C_R, ID_W[15:8]);
    xr(C_R, ID_W[7:0]);
    xr(C_R, ID_W[23:16]);
    xr(C_R | C_N | C_P, ID_W[15:8]);
    xb(C_S | C_B | C_P, 8'hF9, 1'b1);
    xb(C_S | C_B, 8'hF8, 1'b0);
    xb(C_B | C_P, {own ^ 7'h01, 1'b0}, 1'b1);
    xb(C_S | C_B, 8'hF8, 1'b0);
    xb(C_B, {own, 1'b0}, 1'b0);
    xb(C_S | C_B, {own ^ 7'h01, 1'b0}, 1'b1);
    xb(C_S | C_B | C_P, 8'hF9, 1'b1);
  endtask
  task automatic t_own_read();
    port_rd_data <= 8'h3C;
    xb(C_S | C_B, {own, 1'b1}, 1'b0);
    xr(C_R | C_N | C_P, 8'h3C);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    end_sim();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr} = 5'h00;
    {reg_wdata, port_rd_data} = 16'h0000;
    err_total = 0;
    samples_checked = 0;
    n_wr = 0;
    n_rst = 0;
    sel = '{SXP_PIN_GND, SXP_PIN_GND, SXP_PIN_GND};
    t_addr_map();
    t_gc_refuse();
    t_swrst();
    t_ident();
    t_own_read();
    end_sim();
  end
endmodule // sxp_tb
`default_nettype wire
